// file: jbs_pkg.sv
// Constants and types shared by the boundary-scan test access port.
`default_nettype none
package jbs_pkg;
    // Boundary register geometry.
    localparam int IO_N = 4;
    localparam int CELLS = 3;
    localparam int BSR_W = IO_N * CELLS;
    localparam int CELL_IN = 0;
    localparam int CELL_OUT = 1;
    localparam int CELL_OE = 2;
    localparam int IR_W = 5;
    localparam int ID_W = 32;
    // Instruction codes.
    localparam logic [4:0] INS_EXTEST = 5'h00;
    localparam logic [4:0] INS_SAMPLE = 5'h01;
    localparam logic [4:0] INS_USER_CHAIN_ONE_INSTR = 5'h02;
    localparam logic [4:0] INS_USER_CHAIN_TWO_INSTR = 5'h03;
    localparam logic [4:0] INS_CFG_RD = 5'h04;
    localparam logic [4:0] INS_CFG_WR = 5'h05;
    localparam logic [4:0] INS_INTEST = 5'h07;
    localparam logic [4:0] INS_USERCODE = 5'h08;
    localparam logic [4:0] INS_DEVICE_IDENTIFICATION = 5'h09;
    localparam logic [4:0] INS_HIGHZ = 5'h0a;
    localparam logic [4:0] INS_STARTUP = 5'h0c;
    localparam logic [4:0] INS_BYPASS = 5'h1f;
    // Instruction register capture pattern and reset instruction.
    localparam logic [4:0] IR_CAPTURE = 5'h01;
    localparam logic [4:0] IR_RESET = INS_DEVICE_IDENTIFICATION;
    // User code shifted out before configuration completes.
    localparam logic [31:0] USERCODE_BLANK = 32'hffff_ffff;
    // Identification fields; these values are arbitrary.
    localparam logic [3:0] ID_VERSION = 4'h1;
    localparam logic [6:0] ID_FAMILY = 7'h3c;
    localparam logic [8:0] ID_ROWS = 9'h040;
    localparam logic [10:0] ID_MAKER = 11'h2b6;
    localparam logic [31:0] ID_VALUE = {ID_VERSION, ID_FAMILY, ID_ROWS, ID_MAKER, 1'b1};

    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EX1_DR,
        TAP_PAUSE_DR, TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR,
        TAP_EX1_IR, TAP_PAUSE_IR, TAP_EX2_IR, TAP_UPD_IR
    } jbs_tap_e;

    // Shared user scan outputs.
    typedef struct packed {
        logic reset;
        logic shift;
        logic update;
        logic selOne;
        logic selTwo;
        logic tdi;
    } jbs_user_s;

    // Decoded instruction.
    typedef struct packed {
        logic useBsr;
        logic drive;
        logic intest;
        logic highz;
        logic selOne;
        logic selTwo;
        logic cfgRd;
        logic cfgWr;
        logic userCode;
        logic device_identification;
        logic startup;
        logic bypass;
    } jbs_dec_s;

    typedef struct packed {
        logic capture;
        logic shift;
        logic update;
    } jbs_drctl_s;

    typedef struct packed {
        logic [BSR_W-1:0] sh;
        logic [BSR_W-1:0] upd;
    } jbs_bsr_s;

    // Scan clock domain state, rising edge.
    typedef struct packed {
        jbs_tap_e tap;
        logic [IR_W-1:0] ir;
        logic [IR_W-1:0] irSh;
        logic bypass;
        logic [ID_W-1:0] dr;
        logic cfgWrBit;
        logic cfgWrValid;
        logic cfgRdAdv;
        jbs_user_s user;
        logic stTgl;
        logic drive;
        logic intest;
        logic highz;
        logic doneS1;
        logic doneS2;
        logic stTckS1;
        logic stTckS2;
        logic [IO_N-1:0] padS1;
        logic [IO_N-1:0] padS2;
        logic [IO_N-1:0] outS1;
        logic [IO_N-1:0] outS2;
        logic [IO_N-1:0] oeS1;
        logic [IO_N-1:0] oeS2;
        logic [ID_W-1:0] codeS1;
        logic [ID_W-1:0] codeS2;
    } jbs_tck_s;

    // Scan clock domain state, falling edge.
    typedef struct packed {
        logic tdo;
        logic tdoOe;
        logic clkOne;
        logic clkTwo;
    } jbs_neg_s;

    // System clock domain state.
    typedef struct packed {
        logic [2:0] modeS1;
        logic [2:0] modeS2;
        logic [BSR_W-1:0] updS1;
        logic [BSR_W-1:0] updS2;
        logic tglS1;
        logic tglS2;
        logic tglS3;
        logic step;
        logic [IO_N-1:0] padS1;
        logic [IO_N-1:0] padS2;
        logic [IO_N-1:0] padOut;
        logic [IO_N-1:0] padOe;
        logic [IO_N-1:0] coreIn;
    } jbs_sys_s;
endpackage
`default_nettype wire

// file: jbs_bsr.sv
// Boundary register with capture, shift and update stages for every cell.
`default_nettype none
module jbs_bsr (
    input wire logic tck,
    input wire logic rst_n,
    input wire jbs_pkg::jbs_drctl_s ctl,
    input wire logic tdi,
    input wire logic [jbs_pkg::BSR_W-1:0] capVal,
    output logic shiftOut,
    output logic [jbs_pkg::BSR_W-1:0] updVal
);
    jbs_pkg::jbs_bsr_s q;
    jbs_pkg::jbs_bsr_s d;

    // All cells load together on capture; cell 0 lies next to the serial output.
    always_comb begin
        d = q;
        if (ctl.capture) begin
            d.sh = capVal;
        end else if (ctl.shift) begin
            d.sh = {tdi, q.sh[jbs_pkg::BSR_W-1:1]};
        end
        if (ctl.update) begin
            d.upd = q.sh;
        end
    end

    // State register; the update stage resets to all pads released.
    always_ff @(posedge tck or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign shiftOut = q.sh[0];
    assign updVal = q.upd;

    chk_cap_all_cells: assert property (
        @(posedge tck) disable iff (!rst_n) ctl.capture |=> q.sh == $past(capVal))
        else $error("Boundary capture did not load every cell.");
endmodule
`default_nettype wire

// file: jbs_tap.sv
// Boundary-scan test access port: controller, decode, data registers and pad muxes.
`default_nettype none
// Functional notes
// - Decode pin test and sample/preload codes.
// - User codes route through user chains.
// - Configuration read and write bus access.
// - Internal test drives logic from boundary.
// - Shift out user or device identification.
// - High impedance pins with bypass path.
// - Step start-up when scan clock selected.
// - Single flip-flop bypass register.
// - User codes usable only after configuration.
// - Three cells per io block.
// - Cell order: input, output, enable.
// - Capture loads all cells together.
// - Every io block treated alike, independent.
// - Chain selects out, chain returns in.
// - Chain clocks, common input, state outputs.
// - Identification layout, fixed one at bottom.
// - User code valid after configuration only.
module jbs_tap (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdoOe,
    input wire logic [jbs_pkg::IO_N-1:0] padIn,
    output logic [jbs_pkg::IO_N-1:0] padOut,
    output logic [jbs_pkg::IO_N-1:0] padOe,
    input wire logic [jbs_pkg::IO_N-1:0] coreOut,
    input wire logic [jbs_pkg::IO_N-1:0] coreOe,
    output logic [jbs_pkg::IO_N-1:0] coreIn,
    input wire logic configDone,
    input wire logic startupClockSourceTck,
    input wire logic [31:0] userCode,
    input wire logic chainOneReturn,
    input wire logic chainTwoReturn,
    output var jbs_pkg::jbs_user_s userScan,
    output logic chainOneShiftClock,
    output logic chainTwoShiftClock,
    output logic cfgWrBit,
    output logic cfgWrValid,
    input wire logic cfgRdBit,
    output logic cfgRdAdvance,
    output logic startupStep
);
    jbs_pkg::jbs_tck_s q;
    jbs_pkg::jbs_tck_s d;
    jbs_pkg::jbs_neg_s nq;
    jbs_pkg::jbs_neg_s nd;
    jbs_pkg::jbs_sys_s sq;
    jbs_pkg::jbs_sys_s sd;
    jbs_pkg::jbs_dec_s dec;
    jbs_pkg::jbs_dec_s decNext;
    jbs_pkg::jbs_drctl_s bsrCtl;
    logic [jbs_pkg::BSR_W-1:0] bsrCap;
    logic [jbs_pkg::BSR_W-1:0] bsrUpd;
    logic bsrOut;
    logic sysStable;

    // Sixteen-state controller, stepped by the mode select on rising edges.
    function automatic jbs_pkg::jbs_tap_e tapNext(input jbs_pkg::jbs_tap_e s, input logic m);
        unique case (s)
            jbs_pkg::TAP_RESET: tapNext = m ? jbs_pkg::TAP_RESET : jbs_pkg::TAP_IDLE;
            jbs_pkg::TAP_IDLE: tapNext = m ? jbs_pkg::TAP_SEL_DR : jbs_pkg::TAP_IDLE;
            jbs_pkg::TAP_SEL_DR: tapNext = m ? jbs_pkg::TAP_SEL_IR : jbs_pkg::TAP_CAP_DR;
            jbs_pkg::TAP_CAP_DR: tapNext = m ? jbs_pkg::TAP_EX1_DR : jbs_pkg::TAP_SHIFT_DR;
            jbs_pkg::TAP_SHIFT_DR: tapNext = m ? jbs_pkg::TAP_EX1_DR : jbs_pkg::TAP_SHIFT_DR;
            jbs_pkg::TAP_EX1_DR: tapNext = m ? jbs_pkg::TAP_UPD_DR : jbs_pkg::TAP_PAUSE_DR;
            jbs_pkg::TAP_PAUSE_DR: tapNext = m ? jbs_pkg::TAP_EX2_DR : jbs_pkg::TAP_PAUSE_DR;
            jbs_pkg::TAP_EX2_DR: tapNext = m ? jbs_pkg::TAP_UPD_DR : jbs_pkg::TAP_SHIFT_DR;
            jbs_pkg::TAP_UPD_DR: tapNext = m ? jbs_pkg::TAP_SEL_DR : jbs_pkg::TAP_IDLE;
            jbs_pkg::TAP_SEL_IR: tapNext = m ? jbs_pkg::TAP_RESET : jbs_pkg::TAP_CAP_IR;
            jbs_pkg::TAP_CAP_IR: tapNext = m ? jbs_pkg::TAP_EX1_IR : jbs_pkg::TAP_SHIFT_IR;
            jbs_pkg::TAP_SHIFT_IR: tapNext = m ? jbs_pkg::TAP_EX1_IR : jbs_pkg::TAP_SHIFT_IR;
            jbs_pkg::TAP_EX1_IR: tapNext = m ? jbs_pkg::TAP_UPD_IR : jbs_pkg::TAP_PAUSE_IR;
            jbs_pkg::TAP_PAUSE_IR: tapNext = m ? jbs_pkg::TAP_EX2_IR : jbs_pkg::TAP_PAUSE_IR;
            jbs_pkg::TAP_EX2_IR: tapNext = m ? jbs_pkg::TAP_UPD_IR : jbs_pkg::TAP_SHIFT_IR;
            jbs_pkg::TAP_UPD_IR: tapNext = m ? jbs_pkg::TAP_SEL_DR : jbs_pkg::TAP_IDLE;
        endcase
    endfunction

    // Instruction decode; user codes fall back to the bypass before configuration.
    function automatic jbs_pkg::jbs_dec_s decode(input logic [4:0] ir, input logic done);
        jbs_pkg::jbs_dec_s r;
        r = '0;
        case (ir)
            jbs_pkg::INS_EXTEST: begin
                r.useBsr = 1'b1;
                r.drive = 1'b1;
            end
            jbs_pkg::INS_SAMPLE: r.useBsr = 1'b1;
            jbs_pkg::INS_USER_CHAIN_ONE_INSTR: begin
                r.selOne = done;
                r.bypass = !done;
            end
            jbs_pkg::INS_USER_CHAIN_TWO_INSTR: begin
                r.selTwo = done;
                r.bypass = !done;
            end
            jbs_pkg::INS_CFG_RD: r.cfgRd = 1'b1;
            jbs_pkg::INS_CFG_WR: begin
                r.cfgWr = 1'b1;
                r.bypass = 1'b1;
            end
            jbs_pkg::INS_INTEST: begin
                r.useBsr = 1'b1;
                r.drive = 1'b1;
                r.intest = 1'b1;
            end
            jbs_pkg::INS_USERCODE: r.userCode = 1'b1;
            jbs_pkg::INS_DEVICE_IDENTIFICATION: r.device_identification = 1'b1;
            jbs_pkg::INS_HIGHZ: begin
                r.highz = 1'b1;
                r.bypass = 1'b1;
            end
            jbs_pkg::INS_STARTUP: begin
                r.startup = 1'b1;
                r.bypass = 1'b1;
            end
            jbs_pkg::INS_BYPASS: r.bypass = 1'b1;
            default: r.bypass = 1'b1;
        endcase
        return r;
    endfunction

    assign dec = decode(q.ir, q.doneS2);

    // Rising-edge scan logic: controller, instruction and data registers, synchronisers.
    always_comb begin
        d = q;
        d.tap = tapNext(q.tap, tms);
        d.doneS1 = configDone;
        d.doneS2 = q.doneS1;
        d.stTckS1 = startupClockSourceTck;
        d.stTckS2 = q.stTckS1;
        d.padS1 = padIn;
        d.padS2 = q.padS1;
        d.outS1 = coreOut;
        d.outS2 = q.outS1;
        d.oeS1 = coreOe;
        d.oeS2 = q.oeS1;
        d.codeS1 = userCode;
        d.codeS2 = q.codeS1;
        d.cfgWrValid = 1'b0;
        d.cfgRdAdv = 1'b0;
        case (q.tap)
            jbs_pkg::TAP_RESET: d.ir = jbs_pkg::IR_RESET;
            jbs_pkg::TAP_CAP_IR: d.irSh = jbs_pkg::IR_CAPTURE;
            jbs_pkg::TAP_SHIFT_IR: d.irSh = {tdi, q.irSh[jbs_pkg::IR_W-1:1]};
            jbs_pkg::TAP_UPD_IR: d.ir = q.irSh;
            jbs_pkg::TAP_CAP_DR: begin
                d.bypass = 1'b0;
                if (dec.device_identification) begin
                    d.dr = jbs_pkg::ID_VALUE;
                end else if (dec.userCode) begin
                    d.dr = q.doneS2 ? q.codeS2 : jbs_pkg::USERCODE_BLANK;
                end
            end
            jbs_pkg::TAP_SHIFT_DR: begin
                d.bypass = tdi;
                d.dr = {tdi, q.dr[jbs_pkg::ID_W-1:1]};
                if (dec.cfgWr) begin
                    d.cfgWrBit = tdi;
                end
                d.cfgWrValid = dec.cfgWr;
                d.cfgRdAdv = dec.cfgRd;
            end
            jbs_pkg::TAP_IDLE: begin
                if (dec.startup && q.stTckS2) begin
                    d.stTgl = !q.stTgl;
                end
            end
            default: ;
        endcase
        // Modes and chain selects follow the instruction about to be in force; reset, shift and update follow the next controller state.
        decNext = decode(d.ir, q.doneS2);
        d.drive = decNext.drive;
        d.intest = decNext.intest;
        d.highz = decNext.highz;
        d.user.selOne = decNext.selOne;
        d.user.selTwo = decNext.selTwo;
        d.user.reset = d.tap == jbs_pkg::TAP_RESET;
        d.user.shift = d.tap == jbs_pkg::TAP_SHIFT_DR;
        d.user.update = d.tap == jbs_pkg::TAP_UPD_DR;
        d.user.tdi = tdi;
    end

    // Rising-edge register; the instruction resets to identification.
    always_ff @(posedge tck or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
            q.ir <= jbs_pkg::IR_RESET;
        end else begin
            q <= d;
        end
    end

    // Boundary cells per io block, in the order input, output, enable.
    always_comb begin
        bsrCtl.capture = dec.useBsr && q.tap == jbs_pkg::TAP_CAP_DR;
        bsrCtl.shift = dec.useBsr && q.tap == jbs_pkg::TAP_SHIFT_DR;
        bsrCtl.update = dec.useBsr && q.tap == jbs_pkg::TAP_UPD_DR;
        bsrCap = '0;
        for (int k = 0; k < jbs_pkg::IO_N; k++) begin
            bsrCap[jbs_pkg::CELLS*k+jbs_pkg::CELL_IN] = q.padS2[k];
            bsrCap[jbs_pkg::CELLS*k+jbs_pkg::CELL_OUT] = q.outS2[k];
            bsrCap[jbs_pkg::CELLS*k+jbs_pkg::CELL_OE] = q.oeS2[k];
        end
    end

    jbs_bsr bsr (
        .tck(tck),
        .rst_n(rst_n),
        .ctl(bsrCtl),
        .tdi(tdi),
        .capVal(bsrCap),
        .shiftOut(bsrOut),
        .updVal(bsrUpd)
    );

    // Serial output mux and chain clocks, launched on the falling edge.
    always_comb begin
        nd = nq;
        nd.tdoOe = q.tap == jbs_pkg::TAP_SHIFT_DR || q.tap == jbs_pkg::TAP_SHIFT_IR;
        if (q.tap == jbs_pkg::TAP_SHIFT_IR) begin
            nd.tdo = q.irSh[0];
        end else if (dec.useBsr) begin
            nd.tdo = bsrOut;
        end else if (dec.device_identification || dec.userCode) begin
            nd.tdo = q.dr[0];
        end else if (dec.selOne) begin
            nd.tdo = chainOneReturn;
        end else if (dec.selTwo) begin
            nd.tdo = chainTwoReturn;
        end else if (dec.cfgRd) begin
            nd.tdo = cfgRdBit;
        end else begin
            nd.tdo = q.bypass;
        end
        nd.clkOne = dec.selOne && (q.tap == jbs_pkg::TAP_CAP_DR || q.tap == jbs_pkg::TAP_SHIFT_DR);
        nd.clkTwo = dec.selTwo && (q.tap == jbs_pkg::TAP_CAP_DR || q.tap == jbs_pkg::TAP_SHIFT_DR);
    end

    // Falling-edge register keeps the output stable across the far end's sampling edge.
    always_ff @(negedge tck or negedge rst_n) begin
        if (!rst_n) begin
            nq <= '0;
        end else begin
            nq <= nd;
        end
    end

    // System clock side: synchronised modes and cells steer the pads and core inputs.
    always_comb begin
        sd = sq;
        sd.modeS1 = {q.drive, q.intest, q.highz};
        sd.modeS2 = sq.modeS1;
        sd.updS1 = bsrUpd;
        sd.updS2 = sq.updS1;
        sd.tglS1 = q.stTgl;
        sd.tglS2 = sq.tglS1;
        sd.tglS3 = sq.tglS2;
        sd.step = sq.tglS2 ^ sq.tglS3;
        sd.padS1 = padIn;
        sd.padS2 = sq.padS1;
        // A crossed word only steers the pads once two samples agree; high impedance acts at once.
        for (int k = 0; k < jbs_pkg::IO_N; k++) begin
            if (sysStable) begin
                sd.padOut[k] = sq.modeS2[2] ? sq.updS2[jbs_pkg::CELLS*k+jbs_pkg::CELL_OUT]
                                            : coreOut[k];
                sd.padOe[k] = sq.modeS2[2] ? sq.updS2[jbs_pkg::CELLS*k+jbs_pkg::CELL_OE]
                                           : coreOe[k];
                sd.coreIn[k] = sq.modeS2[1] ? sq.updS2[jbs_pkg::CELLS*k+jbs_pkg::CELL_IN]
                                            : sq.padS2[k];
            end
            sd.padOe[k] = sd.padOe[k] && !sq.modeS2[0];
        end
    end

    // Two successive samples of the mode and update words must agree before they are used.
    assign sysStable = sq.modeS1 == sq.modeS2 && sq.updS1 == sq.updS2;

    // System clock register.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sq <= '0;
        end else begin
            sq <= sd;
        end
    end

    // Every output comes straight from a flip-flop.
    assign tdo = nq.tdo;
    assign tdoOe = nq.tdoOe;
    assign chainOneShiftClock = nq.clkOne;
    assign chainTwoShiftClock = nq.clkTwo;
    assign userScan = q.user;
    assign cfgWrBit = q.cfgWrBit;
    assign cfgWrValid = q.cfgWrValid;
    assign cfgRdAdvance = q.cfgRdAdv;
    assign padOut = sq.padOut;
    assign padOe = sq.padOe;
    assign coreIn = sq.coreIn;
    assign startupStep = sq.step;

    // Checks on the scan clock side.
    sequence capIrThenShift;
        q.tap == jbs_pkg::TAP_CAP_IR && !tms;
    endsequence

    chk_ir_capture_shift: assert property (
        @(posedge tck) disable iff (!rst_n)
        capIrThenShift |=> q.tap == jbs_pkg::TAP_SHIFT_IR && q.irSh == jbs_pkg::IR_CAPTURE)
        else $error("Instruction capture pattern not loaded.");

    chk_reset_loads_id: assert property (
        @(posedge tck) disable iff (!rst_n)
        q.tap == jbs_pkg::TAP_RESET |=> q.ir == jbs_pkg::INS_DEVICE_IDENTIFICATION)
        else $error("Controller reset did not select identification.");

    chk_id_capture_value: assert property (
        @(posedge tck) disable iff (!rst_n)
        q.tap == jbs_pkg::TAP_CAP_DR && q.ir == jbs_pkg::INS_DEVICE_IDENTIFICATION |=> q.dr[0] && q.dr == 32'h1784_056d)
        else $error("Identification capture has the wrong value.");

    chk_bypass_capture: assert property (
        @(posedge tck) disable iff (!rst_n)
        q.tap == jbs_pkg::TAP_CAP_DR |=> !q.bypass ##1 (q.tap != jbs_pkg::TAP_SHIFT_DR
        || q.bypass == $past(tdi)))
        else $error("Bypass capture or shift is wrong.");

    chk_user_unconfigured: assert property (
        @(posedge tck) disable iff (!rst_n)
        !q.doneS2 && (q.ir == jbs_pkg::INS_USER_CHAIN_ONE_INSTR || q.ir == jbs_pkg::INS_USER_CHAIN_TWO_INSTR)
        |-> dec.bypass && !dec.selOne && !dec.selTwo)
        else $error("User chain selected before configuration.");

    chk_chain_one_select: assert property (
        @(posedge tck) disable iff (!rst_n)
        q.tap == jbs_pkg::TAP_UPD_IR && q.irSh == jbs_pkg::INS_USER_CHAIN_ONE_INSTR && q.doneS2 && q.doneS1
        |=> q.user.selOne && !q.user.selTwo)
        else $error("First chain select not raised.");

    chk_cfg_write_bit: assert property (
        @(posedge tck) disable iff (!rst_n)
        q.tap == jbs_pkg::TAP_SHIFT_DR && q.ir == jbs_pkg::INS_CFG_WR
        |=> (q.cfgWrValid && q.cfgWrBit == $past(tdi)) ##1 (q.cfgWrValid == $past(q.user.shift)))
        else $error("Configuration write bit not delivered.");

    chk_unknown_bypass: assert property (
        @(posedge tck) disable iff (!rst_n)
        q.ir == 5'h06 |-> dec.bypass && !dec.useBsr && !dec.highz)
        else $error("Reserved code did not select bypass.");

    // Checks on the system clock side.
    chk_highz_release: assert property (
        @(posedge clk) disable iff (!rst_n)
        sq.modeS2[0] |=> padOe == '0)
        else $error("Pads still driven in high impedance mode.");

    chk_startup_step: assert property (
        @(posedge clk) disable iff (!rst_n)
        $changed(sq.tglS2) |=> startupStep ##1 !startupStep || $changed(sq.tglS3))
        else $error("Start-up step pulse missing.");
endmodule
`default_nettype wire

// file: jbs_ctrl_model.sv
// Behavioural model of the external scan test controller.
`default_nettype none
module jbs_ctrl_model (
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo
);
    timeunit 1ns;
    timeprecision 1ps;
    // The scan clock stands still low between frames.
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // One 48 ns cycle: hold mode and data across the rising edge and take tdo there.
    task automatic step(input logic m, input logic d, output logic o);
        tms = m;
        tdi = d;
        #24;
        o = tdo;
        tck = 1'b1;
        #24;
        tck = 1'b0;
    endtask
    // Repeat one mode value; tdi toggles since no data is owed.
    task automatic walk(input logic m, input int n);
        logic o;
        for (int i = 0; i < n; i++) begin
            step(m, ~tdi, o);
        end
    endtask
    // Full instruction or data scan from idle, lsb first, back to idle.
    task automatic scan(input logic ir, input int n, input logic [31:0] din,
                        output logic [31:0] dout);
        logic o;
        dout = '0;
        step(1'b1, ~tdi, o);
        if (ir) begin
            step(1'b1, ~tdi, o);
        end
        walk(1'b0, 2);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], o);
            dout[i] = o;
        end
        step(1'b1, ~tdi, o);
        step(1'b0, ~tdi, o);
    endtask
endmodule
`default_nettype wire

// file: jtag_boundary_scan_tap_bench.sv
// Self-checking bench for the boundary-scan test access port.
`default_nettype none
module jtag_boundary_scan_tap_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst_n = 0, tck, tms, tdi, tdo, tdoOe, tdoLine, cfgDone = 0, srcTck = 0;
    logic retOne = 1, retTwo = 0, stepPulse, cfgRd = 1, wrValid, wrBit, rdAdv, chOne, chTwo;
    logic [7:0] wrBits;
    logic [23:0] linkCnt;
    logic [3:0] padIn = 0, padOut, padOe, coreOut = 0, coreOe = 0, coreIn;
    logic [31:0] userCode = 0, seed = 32'h5bfdba6f, got, pre, exp;
    jbs_pkg::jbs_user_s userScan;
    int badCount = 0, cmpCount = 0, steps = 0;
    logic [4:0] byp[7] = '{jbs_pkg::INS_BYPASS, jbs_pkg::INS_HIGHZ, jbs_pkg::INS_USER_CHAIN_ONE_INSTR,
                          jbs_pkg::INS_USER_CHAIN_TWO_INSTR, 5'h06, 5'h0d, 5'h1e};
    // System clock and the pulled-up tdo wire.
    always #20 clk = ~clk;
    assign tdoLine = tdoOe ? tdo : 1'b1;
    always @(posedge clk) if (stepPulse === 1'b1) steps++;
    // Link-side tallies, one nibble each: update, shift, write, read, chain two, chain one.
    always @(posedge tck) begin
        linkCnt = linkCnt + {3'h0, userScan.update, 3'h0, userScan.shift, 3'h0, wrValid,
                             3'h0, rdAdv, 3'h0, chTwo, 3'h0, chOne};
        if (wrValid === 1'b1) wrBits = {wrBit, wrBits[7:1]};
    end
    jbs_tap jbs_tap_i (.clk(clk), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdoOe(tdoOe), .padIn(padIn), .padOut(padOut), .padOe(padOe), .coreOut(coreOut),
        .coreOe(coreOe), .coreIn(coreIn), .configDone(cfgDone), .startupClockSourceTck(srcTck),
        .userCode(userCode), .chainOneReturn(retOne), .chainTwoReturn(retTwo),
        .userScan(userScan), .chainOneShiftClock(chOne), .chainTwoShiftClock(chTwo),
        .cfgWrBit(wrBit), .cfgWrValid(wrValid), .cfgRdBit(cfgRd), .cfgRdAdvance(rdAdv),
        .startupStep(stepPulse));
    jbs_ctrl_model jbs_ctrl_model_i (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdoLine));
    // Random source for data and pad levels.
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Compare, count and report.
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        cmpCount++;
        if (seen !== want) begin
            badCount++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmpCount, badCount);
        if (badCount == 0 && cmpCount > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Scan helpers; the instruction capture pattern is checked on every load.
    task automatic ir(input logic [4:0] c);
        jbs_ctrl_model_i.scan(1'b1, 5, {27'h0, c}, got);
        check({27'h0, got[4:0]}, {27'h0, jbs_pkg::IR_CAPTURE});
    endtask
    task automatic dr(input int n, input logic [31:0] d);
        jbs_ctrl_model_i.scan(1'b0, n, d, got);
    endtask
    task automatic settle();
        repeat (6) @(posedge clk);
    endtask
    // Watchdog against a hung run.
    initial begin
        #300us;
        badCount++;
        summarize();
    end
    // Main sequence.
    initial begin
        fork
            #1 jbs_ctrl_model_i.walk(1'b1, 1);
            repeat (2) @(posedge clk);
        join
        rst_n <= 1'b1;
        #9;
        jbs_ctrl_model_i.walk(1'b1, 5);
        check({31'h0, userScan.reset}, 32'h1);
        jbs_ctrl_model_i.walk(1'b0, 1);
        seed = lfsr(seed);
        dr(32, seed);
        check(got, jbs_pkg::ID_VALUE);
        $display("test identification done");
        @(posedge clk) coreOe <= 4'hf;
        coreOut <= seed[3:0];
        foreach (byp[i]) begin
            ir(byp[i]);
            dr(8, 32'hff);
            check(got, 32'hfe);
            settle();
            check({28'h0, padOe}, (byp[i] == jbs_pkg::INS_HIGHZ) ? 32'h0 : 32'hf);
        end
        $display("test bypass codes done");
        ir(jbs_pkg::INS_USERCODE);
        dr(32, seed);
        check(got, jbs_pkg::USERCODE_BLANK);
        @(posedge clk) userCode <= seed;
        cfgDone <= 1'b1;
        settle();
        dr(32, ~seed);
        check(got, seed);
        ir(jbs_pkg::INS_USER_CHAIN_ONE_INSTR);
        check({30'h0, userScan.selOne, userScan.selTwo}, 32'h2);
        linkCnt = '0;
        dr(8, 32'h0);
        check(got, 32'hff);
        check({8'h0, linkCnt}, 32'h0018_0009);
        ir(jbs_pkg::INS_USER_CHAIN_TWO_INSTR);
        check({30'h0, userScan.selOne, userScan.selTwo}, 32'h1);
        linkCnt = '0;
        dr(8, 32'hff);
        check(got, 32'h0);
        check({8'h0, linkCnt}, 32'h0018_0090);
        $display("test user chains done");
        ir(jbs_pkg::INS_CFG_RD);
        linkCnt = '0;
        dr(8, 32'h0);
        check(got, 32'hff);
        check({8'h0, linkCnt}, 32'h0018_0800);
        ir(jbs_pkg::INS_CFG_WR);
        linkCnt = '0;
        dr(8, seed);
        check(got, {24'h0, seed[6:0], 1'b0});
        check({8'h0, linkCnt}, 32'h0018_8000);
        check({24'h0, wrBits}, {24'h0, seed[7:0]});
        $display("test configuration access done");
        seed = lfsr(seed);
        @(posedge clk) padIn <= seed[7:4];
        settle();
        ir(jbs_pkg::INS_SAMPLE);
        pre = {20'h0, seed[19:8]};
        dr(12, pre);
        exp = '0;
        for (int k = 0; k < 4; k++) begin
            exp[3*k+:3] = {coreOe[k], coreOut[k], padIn[k]};
        end
        check(got, exp);
        ir(jbs_pkg::INS_EXTEST);
        settle();
        for (int k = 0; k < 4; k++) begin
            check({30'h0, padOe[k], padOut[k]}, {30'h0, pre[3*k+2], pre[3*k+1]});
        end
        ir(jbs_pkg::INS_INTEST);
        settle();
        for (int k = 0; k < 4; k++) begin
            check({31'h0, coreIn[k]}, {31'h0, pre[3*k]});
        end
        $display("test boundary done");
        @(posedge clk) srcTck <= 1'b1;
        settle();
        ir(jbs_pkg::INS_STARTUP);
        settle();
        steps = 0;
        jbs_ctrl_model_i.walk(1'b0, 6);
        settle();
        check(32'(steps), 32'd6);
        $display("test start-up done");
        summarize();
    end
endmodule
`default_nettype wire
